// >>> include/mdio_ctrl_defines.vh
/*
 Offsets, field positions, reset values and timing counts for the
 management serial master control block.
 Assumes inclusion by bare name from the logic files; definitions only.
*/
// Notes on behaviour
// - Control bit 31 reads 1 while the frame engine is idle and 0 while busy.
// - The frame engine starts a frame only while control bit 30 is 1; writing 0 blocks new frames.
// - Clearing the enable mid-frame lets the frame finish, then the engine halts idle.
// - Bits 28-24 read as 1, the highest user channel, so channels 0 and 1 exist.
// - Bit 20 at 0 sends the 32-bit preamble; at 1 every frame omits it.
// - With detection on, a pin readback that differs from drive sets the fault flag and resets the engine.
// - Writing 1 to the fault flag clears it; writing 0 leaves it.
// - Fault detection works only while bit 18 is 1.
// - The management clock runs at the system clock over divisor plus one; divisor resets to FFh.
// - A divisor of 0 stops the management clock.
// - Each of 32 acknowledge flags is set if the latest access to that address was a write or an acknowledged read, else cleared.
// - Acknowledge flags update after every user access that completes.
// - Writing 1 to an acknowledge flag clears it; writing 0 leaves it.
// - After a generic status read, the address's link flag is set if link and acknowledged, else cleared.
`ifndef MDIO_CTRL_DEFINES_VH
`define MDIO_CTRL_DEFINES_VH
`define OFS_CONTROL 12'h004
`define OFS_ACK 12'h008
`define OFS_LINK 12'h00C
`define OFS_CMD 12'h080
`define OFS_IRQ_STAT 12'h0F0
`define OFS_IRQ_MASK 12'h0F4
`define BIT_IDLE 31
`define BIT_ENABLE 30
`define BIT_PREAMBLE_OFF 20
`define BIT_FAULT 19
`define BIT_FAULT_EN 18
`define HIGHEST_USER_CHANNEL 5'h01
`define DIVISOR_RESET 16'h00FF
`define CMD_GO 31
`define CMD_WRITE 30
`define PREAMBLE_BITS 6'h20
`define FRAME_BITS 6'h20
`define STATUS_REG_ADDR 5'h01
`define LINK_BIT 2
`define IRQ_DONE 0
`define IRQ_FAULT 1
`define IRQ_LINK 2
`endif

// >>> logic/mdio_master_control_status.v
/*
 Management serial master: control/status registers, divided clock,
 frame engine with readback fault check, per-address acknowledge/link flags.
 Assumes an APB master on CLK_SYS and a pull-up on the shared data wire.
*/
`timescale 1ns/1ns
`include "mdio_ctrl_defines.vh"
module mdio_master_control_status (
    input wire CLK_SYS,
    input wire RESET_N,
    input wire CLK_EN,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    output reg IRQ,
    output reg MGMT_CLOCK_OUT,
    input wire MDIO_IN,
    output reg MDIO_OUT,
    output reg MDIO_OE
);
    localparam ST_IDLE = 2'd0;
    localparam ST_PRE = 2'd1;
    localparam ST_FRAME = 2'd2;

    reg enable_q;
    reg preamble_off_q;
    reg fault_q;
    reg fault_detect_en_q;
    reg [15:0] mgmt_clock_divisor_q;
    reg [31:0] ack_q;
    reg [31:0] link_q;
    reg [2:0] irq_stat_q;
    reg [2:0] irq_mask_q;
    reg [1:0] state_q;
    reg [5:0] bit_cnt_q;
    reg [31:0] shift_q;
    reg [15:0] rd_data_q;
    reg [15:0] div_cnt_q;
    reg cmd_pend_q;
    reg cmd_write_q;
    reg [4:0] cmd_phy_q;
    reg [4:0] cmd_reg_q;
    reg [15:0] cmd_data_q;
    reg ack_seen_q;
    reg drive_chk_q;
    reg drive_val_q;

    wire apb_access = PSEL & PENABLE & ~PREADY;
    wire apb_wr = apb_access & PWRITE;
    wire busy = (state_q != ST_IDLE);
    wire [31:0] control_rd = {~busy, enable_q, 1'b0, `HIGHEST_USER_CHANNEL,
        3'b000, preamble_off_q, fault_q, fault_detect_en_q, 2'b00, mgmt_clock_divisor_q};
    wire rise = (mgmt_clock_divisor_q != 16'h0000) && (div_cnt_q == 16'h0000)
        && !MGMT_CLOCK_OUT;
    wire fall = (mgmt_clock_divisor_q != 16'h0000) && (div_cnt_q == 16'h0000)
        && MGMT_CLOCK_OUT;
    wire [15:0] half_div = {1'b0, mgmt_clock_divisor_q[15:1]};
    wire [31:0] frame_word = {2'b01, cmd_write_q ? 2'b01 : 2'b10, cmd_phy_q,
        cmd_reg_q, 2'b10, cmd_data_q};
    // Last data bit lands in the same cycle as frame end
    wire [15:0] rd_next = {rd_data_q[14:0], MDIO_IN};
    // Readback fault: sample at rise while driving
    wire fault_hit = fault_detect_en_q && drive_chk_q && rise
        && (MDIO_IN != drive_val_q);
    // Second turnaround bit: the PHY must pull low
    wire in_ta = (state_q == ST_FRAME) && (bit_cnt_q == 6'd16);
    wire frame_done = (state_q == ST_FRAME) && (bit_cnt_q == 6'd0) && rise;
    wire done_ev = frame_done && !cmd_write_q;
    wire wr_ctrl = apb_wr && (PADDR == `OFS_CONTROL);
    wire wr_ack = apb_wr && (PADDR == `OFS_ACK);
    wire wr_cmd = apb_wr && (PADDR == `OFS_CMD);
    wire wr_stat = apb_wr && (PADDR == `OFS_IRQ_STAT);
    wire link_chg = done_ev && (cmd_reg_q == `STATUS_REG_ADDR) && (link_q[cmd_phy_q] !=
        (ack_seen_q & rd_next[`LINK_BIT]));
    reg [2:0] ev;
    reg [31:0] rd_d;

    always @* begin
        ev = {link_chg, fault_hit, frame_done};
        rd_d = 32'h0000_0000;
        if (PADDR == `OFS_CONTROL) begin
            rd_d = control_rd;
        end else if (PADDR == `OFS_ACK) begin
            rd_d = ack_q;
        end else if (PADDR == `OFS_LINK) begin
            rd_d = link_q;
        end else if (PADDR == `OFS_CMD) begin
            rd_d = {cmd_pend_q, cmd_write_q, ack_seen_q, cmd_reg_q, cmd_phy_q, 3'b000, rd_data_q};
        end else if (PADDR == `OFS_IRQ_STAT) begin
            rd_d = {29'h0, irq_stat_q};
        end else if (PADDR == `OFS_IRQ_MASK) begin
            rd_d = {29'h0, irq_mask_q};
        end
    end

    wire addr_ok = (PADDR == `OFS_CONTROL) || (PADDR == `OFS_ACK) || (PADDR == `OFS_LINK)
        || (PADDR == `OFS_CMD) || (PADDR == `OFS_IRQ_STAT) || (PADDR == `OFS_IRQ_MASK);

    // Bus slave: answer one cycle into access phase
    always @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
        end else if (CLK_EN) begin
            PREADY <= apb_access;
            PSLVERR <= apb_access & ~addr_ok;
            if (apb_access && !PWRITE) begin
                PRDATA <= rd_d;
            end
        end
    end

    // Control fields and sticky flags
    always @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            enable_q <= 1'b0;
            preamble_off_q <= 1'b0;
            fault_detect_en_q <= 1'b0;
            mgmt_clock_divisor_q <= `DIVISOR_RESET;
            fault_q <= 1'b0;
            irq_stat_q <= 3'b000;
            irq_mask_q <= 3'b000;
            IRQ <= 1'b0;
        end else if (CLK_EN) begin
            if (wr_ctrl) begin
                enable_q <= PWDATA[`BIT_ENABLE];
                preamble_off_q <= PWDATA[`BIT_PREAMBLE_OFF];
                fault_detect_en_q <= PWDATA[`BIT_FAULT_EN];
                mgmt_clock_divisor_q <= PWDATA[15:0];
            end
            // Set wins over a same-cycle clear
            fault_q <= fault_hit | (fault_q & ~(wr_ctrl & PWDATA[`BIT_FAULT]));
            irq_stat_q <= ev | (irq_stat_q & ~(wr_stat ? PWDATA[2:0] : 3'b000));
            if (apb_wr && PADDR == `OFS_IRQ_MASK) begin
                irq_mask_q <= PWDATA[2:0];
            end
            IRQ <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Clock divider: each full period lasts divisor+1 cycles, toggling twice
    always @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            div_cnt_q <= 16'h0000;
            MGMT_CLOCK_OUT <= 1'b0;
        end else if (CLK_EN) begin
            if (mgmt_clock_divisor_q == 16'h0000) begin
                div_cnt_q <= 16'h0000;
                MGMT_CLOCK_OUT <= 1'b0;
            end else if (div_cnt_q == 16'h0000) begin
                // Even divisors give an uneven duty split
                div_cnt_q <= MGMT_CLOCK_OUT ? half_div : mgmt_clock_divisor_q - half_div - 16'h0001;
                MGMT_CLOCK_OUT <= ~MGMT_CLOCK_OUT;
            end else begin
                div_cnt_q <= div_cnt_q - 16'h0001;
            end
        end
    end

    // Frame engine: data changes on falling edge, sampled on rising
    always @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 6'h00;
            shift_q <= 32'h0000_0000;
            rd_data_q <= 16'h0000;
            cmd_pend_q <= 1'b0;
            cmd_write_q <= 1'b0;
            cmd_phy_q <= 5'h00;
            cmd_reg_q <= 5'h00;
            cmd_data_q <= 16'h0000;
            ack_seen_q <= 1'b0;
            ack_q <= 32'h0000_0000;
            link_q <= 32'h0000_0000;
            MDIO_OUT <= 1'b1;
            MDIO_OE <= 1'b0;
            drive_chk_q <= 1'b0;
            drive_val_q <= 1'b1;
        end else if (CLK_EN) begin
            if (wr_cmd && !cmd_pend_q) begin
                cmd_pend_q <= PWDATA[`CMD_GO];
                cmd_write_q <= PWDATA[`CMD_WRITE];
                cmd_reg_q <= PWDATA[25:21];
                cmd_phy_q <= PWDATA[20:16];
                cmd_data_q <= PWDATA[15:0];
            end
            if (wr_ack) begin
                ack_q <= ack_q & ~PWDATA;
            end
            if (fault_hit) begin
                state_q <= ST_IDLE;
                cmd_pend_q <= 1'b0;
                MDIO_OE <= 1'b0;
                drive_chk_q <= 1'b0;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        // Halts only between frames
                        if (enable_q && cmd_pend_q && fall) begin
                            shift_q <= frame_word;
                            ack_seen_q <= 1'b0;
                            MDIO_OE <= 1'b1;
                            MDIO_OUT <= 1'b1;
                            drive_val_q <= 1'b1;
                            drive_chk_q <= 1'b1;
                            if (preamble_off_q) begin
                                // Start edge already carries the first frame bit
                                MDIO_OUT <= frame_word[31];
                                drive_val_q <= frame_word[31];
                                shift_q <= {frame_word[30:0], 1'b0};
                                state_q <= ST_FRAME;
                                bit_cnt_q <= `FRAME_BITS - 6'h01;
                            end else begin
                                // Start edge already carries the first preamble one
                                state_q <= ST_PRE;
                                bit_cnt_q <= `PREAMBLE_BITS - 6'h02;
                            end
                        end
                    end
                    ST_PRE: begin
                        if (fall) begin
                            if (bit_cnt_q == 6'h00) begin
                                state_q <= ST_FRAME;
                                bit_cnt_q <= `FRAME_BITS;
                            end else begin
                                bit_cnt_q <= bit_cnt_q - 6'h01;
                            end
                        end
                    end
                    default: begin
                        if (fall && bit_cnt_q != 6'h00) begin
                            MDIO_OUT <= shift_q[31];
                            drive_val_q <= shift_q[31];
                            shift_q <= {shift_q[30:0], 1'b0};
                            bit_cnt_q <= bit_cnt_q - 6'h01;
                            // Release line for read turnaround and data
                            if (!cmd_write_q && bit_cnt_q <= 6'd18) begin
                                MDIO_OE <= 1'b0;
                                drive_chk_q <= 1'b0;
                            end
                        end
                        if (rise && !cmd_write_q) begin
                            if (in_ta) begin
                                ack_seen_q <= ~MDIO_IN;
                            end
                            if (bit_cnt_q <= 6'd16) begin
                                rd_data_q <= rd_next;
                            end
                        end
                        if (frame_done) begin
                            state_q <= ST_IDLE;
                            cmd_pend_q <= 1'b0;
                            MDIO_OE <= 1'b0;
                            drive_chk_q <= 1'b0;
                            // Writes carry no acknowledge, so counted acknowledged
                            ack_q[cmd_phy_q] <= cmd_write_q | ack_seen_q;
                            if (!cmd_write_q && cmd_reg_q == `STATUS_REG_ADDR) begin
                                link_q[cmd_phy_q] <= ack_seen_q & rd_next[`LINK_BIT];
                            end
                        end
                    end
                endcase
            end
        end
    end
endmodule

// >>> verification/mdio_ctl_properties.sv
/* Port checker for the management serial control block.
 Bound to the top module; shadows control writes seen on APB. */
`timescale 1ns/1ns
`include "mdio_ctrl_defines.vh"
module mdio_ctl_properties (
    input wire CLK_SYS,
    input wire RESET_N,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    input wire PREADY,
    input wire PSLVERR,
    input wire MGMT_CLOCK_OUT,
    input wire MDIO_IN,
    input wire MDIO_OUT,
    input wire MDIO_OE
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);
    reg [15:0] div_q;
    reg [16:0] cnt_q;
    reg en_q, fen_q, prev_q, seen_q;
    wire wr = PSEL && PENABLE && PWRITE && !PREADY && PADDR == `OFS_CONTROL;
    wire rise = MGMT_CLOCK_OUT && !prev_q;
    always @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            {div_q, en_q, fen_q, prev_q, seen_q} <= {16'h00FF, 4'h0};
            cnt_q <= 17'h00000;
        end else begin
            if (wr) {div_q, en_q, fen_q} <= {PWDATA[15:0], PWDATA[30], PWDATA[18]};
            prev_q <= MGMT_CLOCK_OUT;
            // A divisor change spoils the period in flight
            seen_q <= (rise || seen_q) && !wr;
            cnt_q <= rise ? 17'h00001 : cnt_q + 17'h00001;
        end
    end
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready held more than one cycle");
    a_ready_answer: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("access phase not answered next cycle");
    a_ready_cause: assert property (PREADY |-> $past(PSEL && PENABLE))
        else $error("ready without an access phase");
    a_err_with_ready: assert property (PSLVERR |-> PREADY)
        else $error("error response without ready");
    a_clock_period: assert property (rise && seen_q |-> cnt_q == div_q + 17'h00001)
        else $error("management clock period wrong");
    a_clock_stopped: assert property (div_q == 16'h0000 && $past(div_q) == 16'h0000
        |=> !MGMT_CLOCK_OUT) else $error("management clock runs with divisor zero");
    a_disabled_quiet: assert property (!en_q && !MDIO_OE |=> !MDIO_OE)
        else $error("frame started while disabled");
    a_fault_abort: assert property ((fen_q && MDIO_OE && MDIO_OUT != MDIO_IN) [*2]
        |-> ##[1:600] !MDIO_OE) else $error("readback fault did not stop the frame");
endmodule
bind mdio_master_control_status mdio_ctl_properties i_props (.CLK_SYS(CLK_SYS),
    .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .MGMT_CLOCK_OUT(MGMT_CLOCK_OUT),
    .MDIO_IN(MDIO_IN), .MDIO_OUT(MDIO_OUT), .MDIO_OE(MDIO_OE));

// >>> verification/mdio_phy_model.sv
/* Behavioural PHY that answers reads to one address.
 The bench resolves the wire with a pull-up. */
`timescale 1ns/1ns
module mdio_phy_model #(parameter [4:0] ADDR = 5'h05, parameter [15:0] DATA = 16'hA5C3) (
    input wire mdc,
    input wire mdio,
    output reg oe,
    output reg out
);
    reg [13:0] sh;
    integer n;
    initial {sh, n, oe, out} = {14'h0000, 32'h00000063, 2'h1};
    always @(posedge mdc) sh <= {sh[12:0], mdio};
    always @(negedge mdc) begin
        // Guard stops our own data bits from re-arming a reply
        if (sh[13:5] == {4'h6, ADDR} && n > 18) n = 1;
        else n = n + 1;
        oe <= n >= 2 && n <= 18;
        out <= (n < 3 || n > 18) ? 1'h0 : DATA[18 - n];
    end
endmodule

// >>> verification/mdio_master_control_status_tb.sv
/* Self-checking bench: APB master, PHY model and a jammer on the wire.
 Assumes the control block and its defines header. */
`timescale 1ns/1ns
`include "mdio_ctrl_defines.vh"
module mdio_master_control_status_tb;
    reg clk = 1'h0, rst_n = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0, jam = 1'h0, err;
    reg [11:0] pa = 12'h000;
    reg [31:0] pwd = 32'h0, rd;
    wire [31:0] prd;
    wire prdy, perr, irq, mdc, mout, moe, poe, pout;
    wire mdio = jam ? 1'h0 : moe ? mout : poe ? pout : 1'h1;
    integer n_mismatch = 0, samples_checked = 0, cyc = 0, oe_n = 0, b0, i, b;
    time t0;
    always #5 clk = !clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        oe_n <= oe_n + moe;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            results;
        end
    end
    mdio_master_control_status i_dut (.CLK_SYS(clk), .RESET_N(rst_n), .CLK_EN(1'h1),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd),
        .PREADY(prdy), .PSLVERR(perr), .IRQ(irq), .MGMT_CLOCK_OUT(mdc), .MDIO_IN(mdio),
        .MDIO_OUT(mout), .MDIO_OE(moe));
    mdio_phy_model i_phy (.mdc(mdc), .mdio(mdio), .oe(poe), .out(pout));
    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge clk);
            {psel, pen, pwr, pa, pwd} <= {2'h2, w, a, d};
            @(posedge clk);
            pen <= 1'h1;
            @(posedge clk);
            while (prdy !== 1'h1) @(posedge clk);
            {rd, err} = {prd, perr};
            {psel, pen} <= 2'h0;
        end
    endtask
    function [31:0] cv(input e, input p, input f);
        cv = {1'h0, e, 9'h000, p, 1'h0, f, 18'h00001};
    endfunction
    function [31:0] cmd(input w, input [4:0] p);
        cmd = {1'h1, w, 4'h0, 5'h03, p, 16'h1234};
    endfunction
    task idle;
        for (i = 0; i < 300; i = i + 1) begin
            apb(1'h0, `OFS_CMD, 32'h0);
            b = rd[31];
            apb(1'h0, `OFS_CONTROL, 32'h0);
            if (!b && rd[31]) i = 300;
        end
        if (i == 300) chk(32'h0, 32'h1);
    endtask
    task frame(input [31:0] c, input [31:0] w, input [31:0] exp);
        begin
            b0 = oe_n;
            apb(1'h1, `OFS_CONTROL, c);
            apb(1'h1, `OFS_CMD, w);
            idle;
            if (exp != 0) chk(oe_n - b0, exp);
        end
    endtask
    task t_regs;
        begin
            apb(1'h0, `OFS_CONTROL, 32'h0);
            chk(rd, 32'h810000FF);
            apb(1'h0, `OFS_ACK, 32'h0);
            chk(rd, 32'h0);
            apb(1'h0, 12'h100, 32'h0);
            chk(err, 1);
            chk(rd, 32'h0);
        end
    endtask
    task t_clk;
        begin
            for (i = 1; i < 10; i = i * 3) begin
                apb(1'h1, `OFS_CONTROL, i);
                @(posedge mdc) t0 = $time;
                @(posedge mdc) chk($time - t0, i * 10 + 10);
            end
            apb(1'h1, `OFS_CONTROL, 32'h0);
            b = 0;
            repeat (50) @(posedge clk) b = b | mdc;
            chk(b, 0);
        end
    endtask
    task t_frame;
        begin
            frame(cv(1, 0, 0), cmd(1, 6), 127);
            frame(cv(1, 1, 0), cmd(0, 5), 28);
            apb(1'h0, `OFS_CMD, 32'h0);
            chk(rd & 32'h2000FFFF, 32'h2000A5C3);
            apb(1'h0, `OFS_ACK, 32'h0);
            chk(rd, 32'h60);
            frame(cv(1, 1, 0), cmd(0, 6), 28);
            apb(1'h0, `OFS_ACK, 32'h0);
            chk(rd, 32'h20);
            apb(1'h1, `OFS_ACK, 32'h0);
            apb(1'h0, `OFS_ACK, 32'h0);
            chk(rd, 32'h20);
            apb(1'h1, `OFS_ACK, 32'h20);
            apb(1'h0, `OFS_ACK, 32'h0);
            chk(rd, 32'h0);
            apb(1'h1, `OFS_IRQ_MASK, 32'h1);
            repeat (2) @(posedge clk);
            chk(irq, 1);
            apb(1'h1, `OFS_IRQ_STAT, 32'h1);
            apb(1'h1, `OFS_IRQ_MASK, 32'h0);
            chk(irq, 0);
        end
    endtask
    task t_dis;
        begin
            b0 = oe_n;
            apb(1'h1, `OFS_CONTROL, cv(0, 1, 0));
            apb(1'h1, `OFS_CMD, cmd(1, 6));
            repeat (100) @(posedge clk);
            apb(1'h0, `OFS_CONTROL, 32'h0);
            chk(rd[31:30], 2'h2);
            chk(oe_n - b0, 0);
            apb(1'h1, `OFS_CONTROL, cv(1, 1, 0));
            @(posedge moe);
            apb(1'h1, `OFS_CONTROL, cv(0, 1, 0));
            apb(1'h0, `OFS_CONTROL, 32'h0);
            chk(rd[31], 0);
            idle;
            chk(oe_n - b0, 63);
            apb(1'h0, `OFS_IRQ_STAT, 32'h0);
            chk({rd[0], irq}, 2'h2);
        end
    endtask
    task t_fault;
        begin
            @(posedge clk) jam <= 1'h1;
            frame(cv(1, 1, 0), cmd(1, 6), 63);
            chk(rd[19], 0);
            frame(cv(1, 1, 1), cmd(1, 6), 0);
            chk({rd[31], rd[19], oe_n - b0 < 63}, 3'h7);
            @(posedge clk) jam <= 1'h0;
            apb(1'h1, `OFS_CONTROL, cv(1, 1, 1));
            apb(1'h0, `OFS_CONTROL, 32'h0);
            chk(rd[19], 1);
            apb(1'h1, `OFS_CONTROL, cv(1, 1, 1) | 32'h00080000);
            apb(1'h0, `OFS_CONTROL, 32'h0);
            chk(rd[19], 0);
        end
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
            if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        t_regs;
        $display("test regs done");
        t_clk;
        $display("test clock done");
        t_frame;
        $display("test frame done");
        t_dis;
        $display("test disable done");
        t_fault;
        $display("test fault done");
        results;
    end
endmodule
